// File: rtl/fcs_pkg.sv
package fcs_pkg;
  // Counter, frame number, offset and chip offset widths
  localparam int FCS_CNT_W = 8;
  localparam int FCS_FN_W = 12;
  localparam int FCS_DOFF_W = 10;
  localparam int FCS_OFF_W = 8;
  localparam int FCS_CHIP_W = 16;
  // Offset arithmetic: default offset unit is 512 chips, one frame is 38400 chips
  localparam int FCS_DOFF_UNIT = 512;
  localparam int FCS_FRAME_CHIPS = 38400;
  // Reset values
  localparam logic [7:0] FCS_CNT_RST = 8'h00;
  localparam logic [7:0] FCS_OFF_DEF = 8'hFF;
  localparam logic [15:0] FCS_CHIP_DEF = 16'hFFFF;
  // Operating modes
  typedef enum logic {FCS_MODE_FDD, FCS_MODE_TDD} fcs_mode_t;
  // Controller states
  typedef enum logic [1:0] {FCS_IDLE, FCS_RUN, FCS_WAIT_FN} fcs_state_t;
endpackage

// File: rtl/fcs_link_if.sv
// Frame timing signals shared between the counter and its offset reporter
interface fcs_link_if;
  import fcs_pkg::*;
  logic [FCS_CNT_W-1:0] cnt;
  logic [FCS_FN_W-1:0] tgt_fn;
  logic tgt_ok;
  logic [FCS_CHIP_W-1:0] tgt_chip;
  fcs_mode_t mode;
  logic to_tdd;
  logic req;
  logic [FCS_OFF_W-1:0] off;
  logic [FCS_CHIP_W-1:0] chip;
  logic chip_ok;
  logic vld;
  modport ctl (output cnt, tgt_fn, tgt_ok, tgt_chip, mode, to_tdd, req,
    input off, chip, chip_ok, vld);
  modport rep (input cnt, tgt_fn, tgt_ok, tgt_chip, mode, to_tdd, req,
    output off, chip, chip_ok, vld);
endinterface

// File: rtl/fcs_offset_report.sv
// Computes one target offset report from a cell frame number and the count
module fcs_offset_report
  import fcs_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  fcs_link_if.rep lnk
);
  import fcs_pkg::*;

  typedef struct packed {
    logic [FCS_OFF_W-1:0] off;
    logic [FCS_CHIP_W-1:0] chip;
    logic chip_ok;
    logic vld;
  } fcs_rep_st_t;

  fcs_rep_st_t s_q;
  fcs_rep_st_t s_d;
  logic [FCS_OFF_W-1:0] diff;

  // Offset difference modulo 256 falls out of the 8-bit subtraction
  assign diff = lnk.tgt_fn[FCS_OFF_W-1:0] - lnk.cnt;

  // Next report on each request
  always_comb
  begin
    s_d = s_q;
    s_d.vld = 1'b0;
    if (lnk.req)
    begin
      s_d.vld = 1'b1;
      s_d.off = lnk.tgt_ok ? diff : FCS_OFF_DEF;
      s_d.chip = lnk.tgt_ok ? lnk.tgt_chip : FCS_CHIP_DEF;
      s_d.chip_ok = (lnk.mode == FCS_MODE_FDD) && !lnk.to_tdd;
    end
  end

  // State register
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      s_q <= '{off: FCS_OFF_DEF, chip: FCS_CHIP_DEF, chip_ok: 1'b0, vld: 1'b0};
    else
      s_q <= s_d;
  end

  assign lnk.off = s_q.off;
  assign lnk.chip = s_q.chip;
  assign lnk.chip_ok = s_q.chip_ok;
  assign lnk.vld = s_q.vld;

  // Each report carries the difference, or the default when unmeasurable
  property p_rep_diff;
    @(posedge clk) disable iff (!rst_n)
    lnk.req && lnk.tgt_ok |=> lnk.vld && lnk.off == $past(diff);
  endproperty
  a_rep_diff: assert property (p_rep_diff)
    else $error("offset report not target minus count");
  property p_rep_def;
    @(posedge clk) disable iff (!rst_n)
    lnk.req && !lnk.tgt_ok |=> lnk.off == FCS_OFF_DEF;
  endproperty
  a_rep_def: assert property (p_rep_def)
    else $error("default offset not reported");
endmodule

// File: rtl/fcs_frame_counter.sv
module fcs_frame_counter
  import fcs_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire fcs_pkg::fcs_mode_t mode,
  input wire logic frame_tick,
  input wire logic init_req,
  input wire logic [fcs_pkg::FCS_FN_W-1:0] cell_frame_number,
  input wire logic [fcs_pkg::FCS_DOFF_W-1:0] default_offset_fdd,
  input wire logic [fcs_pkg::FCS_OFF_W-1:0] default_offset_tdd,
  input wire logic ho_req,
  input wire logic ho_new_doff,
  input wire logic ho_frame_valid,
  input wire logic rep_req,
  input wire logic [fcs_pkg::FCS_FN_W-1:0] rep_frame_number,
  input wire logic rep_measurable,
  input wire logic [fcs_pkg::FCS_CHIP_W-1:0] rep_chip,
  input wire logic rep_to_tdd,
  input wire logic cfg_arm,
  input wire logic [fcs_pkg::FCS_CNT_W-1:0] cfg_switch_count,
  output logic [fcs_pkg::FCS_CNT_W-1:0] connection_frame_count,
  output logic count_valid,
  output logic cfg_switch,
  output logic cfg_pending,
  output logic [fcs_pkg::FCS_OFF_W-1:0] frame_offset_report,
  output logic [fcs_pkg::FCS_CHIP_W-1:0] chip_offset_report,
  output logic chip_offset_valid,
  output logic report_valid
);
  import fcs_pkg::*;

  typedef struct packed {
    fcs_state_t st;
    logic [FCS_CNT_W-1:0] cnt;
    logic armed;
    logic [FCS_CNT_W-1:0] sw_cnt;
    logic sw;
    logic [FCS_DOFF_W-1:0] doff;
    logic [FCS_OFF_W-1:0] doff_t;
    logic valid;
  } fcs_st_t;

  fcs_st_t s_q;
  fcs_st_t s_d;
  logic [FCS_CNT_W-1:0] init_val;
  logic [FCS_CNT_W-1:0] reinit_val;
  logic [FCS_CNT_W-1:0] frames_fdd;
  logic [FCS_CNT_W-1:0] frames_fdd_ho;
  fcs_link_if lnk ();

  // Whole frames of a default offset: doff*512 div 38400 (doff < 1024 gives < 14)
  function automatic logic [FCS_CNT_W-1:0] doff_frames(input logic [FCS_DOFF_W-1:0] d);
    logic [31:0] chips;
    chips = 32'(d) * 32'(FCS_DOFF_UNIT);
    return FCS_CNT_W'(chips / 32'(FCS_FRAME_CHIPS));
  endfunction

  assign frames_fdd = doff_frames(default_offset_fdd);
  assign frames_fdd_ho = doff_frames(s_q.doff);

  // Initial value from the reference or serving cell frame number, mod 256
  assign init_val = (mode == FCS_MODE_FDD)
    ? cell_frame_number[FCS_CNT_W-1:0] - frames_fdd
    : cell_frame_number[FCS_CNT_W-1:0] - default_offset_tdd;
  // Post-handover value from the latched new default offset
  assign reinit_val = (mode == FCS_MODE_FDD)
    ? cell_frame_number[FCS_CNT_W-1:0] - frames_fdd_ho
    : cell_frame_number[FCS_CNT_W-1:0] - s_q.doff_t;

  // Counter, handover and configuration switch control
  always_comb
  begin
    s_d = s_q;
    s_d.sw = 1'b0;
    unique case (s_q.st)
      FCS_IDLE:
      begin
        if (init_req)
        begin
          s_d.cnt = init_val;
          s_d.st = FCS_RUN;
          s_d.valid = 1'b1;
        end
      end
      FCS_RUN:
      begin
        if (frame_tick)
          s_d.cnt = s_q.cnt + 8'h01;
        if (init_req)
          s_d.cnt = init_val;
        else if (ho_req && ho_new_doff)
        begin
          s_d.doff = default_offset_fdd;
          s_d.doff_t = default_offset_tdd;
          s_d.st = FCS_WAIT_FN;
        end
        // A handover without a new default offset leaves the count alone
      end
      FCS_WAIT_FN:
      begin
        if (frame_tick)
          s_d.cnt = s_q.cnt + 8'h01;
        if (ho_frame_valid)
        begin
          s_d.cnt = reinit_val;
          s_d.st = FCS_RUN;
        end
      end
    endcase
    // Switch on the frame boundary that brings the count to the signalled value
    if (s_q.armed && s_q.st != FCS_IDLE && frame_tick && s_d.cnt == s_q.sw_cnt)
    begin
      s_d.sw = 1'b1;
      s_d.armed = 1'b0;
    end
    if (cfg_arm)
    begin
      s_d.armed = 1'b1;
      s_d.sw_cnt = cfg_switch_count;
    end
  end

  // State register
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      s_q <= '{st: FCS_IDLE, cnt: FCS_CNT_RST, armed: 1'b0, sw_cnt: FCS_CNT_RST,
               sw: 1'b0, doff: '0, doff_t: '0, valid: 1'b0};
    else
      s_q <= s_d;
  end

  // Offset reporter fed with the live count
  assign lnk.cnt = s_q.cnt;
  assign lnk.tgt_fn = rep_frame_number;
  assign lnk.tgt_ok = rep_measurable;
  assign lnk.tgt_chip = rep_chip;
  assign lnk.mode = mode;
  assign lnk.to_tdd = rep_to_tdd;
  assign lnk.req = rep_req;

  fcs_offset_report u_rep (
    .clk(clk),
    .rst_n(rst_n),
    .lnk(lnk)
  );

  assign connection_frame_count = s_q.cnt;
  assign count_valid = s_q.valid;
  assign cfg_switch = s_q.sw;
  assign cfg_pending = s_q.armed;
  assign frame_offset_report = lnk.off;
  assign chip_offset_report = lnk.chip;
  assign chip_offset_valid = lnk.chip_ok;
  assign report_valid = lnk.vld;

  // Handover steps: the new-offset command, then the target frame number
  sequence s_ho_new;
    s_q.st == FCS_RUN && ho_req && ho_new_doff && !init_req;
  endsequence
  sequence s_ho_reload;
    s_q.st == FCS_WAIT_FN && ho_frame_valid;
  endsequence

  // Counter stepping, loading and holding
  property p_step;
    @(posedge clk) disable iff (!rst_n)
    s_q.st == FCS_RUN && frame_tick && !init_req && !ho_req
    |=> connection_frame_count == $past(s_q.cnt) + 8'h01;
  endproperty
  a_step: assert property (p_step)
    else $error("count did not step once per frame");
  property p_hold;
    @(posedge clk) disable iff (!rst_n)
    s_q.st == FCS_RUN && !frame_tick && !init_req
    |=> $stable(connection_frame_count);
  endproperty
  a_hold: assert property (p_hold)
    else $error("count changed without a frame");
  property p_init;
    @(posedge clk) disable iff (!rst_n)
    init_req && s_q.st != FCS_WAIT_FN
    |=> connection_frame_count == $past(init_val) && count_valid;
  endproperty
  a_init: assert property (p_init)
    else $error("initial count wrong");

  // Handover with and without a new default offset
  property p_ho_keep;
    @(posedge clk) disable iff (!rst_n)
    s_q.st == FCS_RUN && ho_req && !ho_new_doff && !init_req |=> s_q.st == FCS_RUN;
  endproperty
  a_ho_keep: assert property (p_ho_keep)
    else $error("handover with known offset re-initialised");
  property p_ho_new;
    @(posedge clk) disable iff (!rst_n)
    s_ho_new |=> s_q.st == FCS_WAIT_FN;
  endproperty
  a_ho_new: assert property (p_ho_new)
    else $error("new offset handover not waiting");
  property p_reinit;
    @(posedge clk) disable iff (!rst_n)
    s_ho_reload |=> connection_frame_count == $past(reinit_val) && count_valid;
  endproperty
  a_reinit: assert property (p_reinit)
    else $error("re-initialisation wrong");

  // Configuration switch and wrap
  property p_switch;
    @(posedge clk) disable iff (!rst_n)
    cfg_switch |-> connection_frame_count == $past(s_q.sw_cnt);
  endproperty
  a_switch: assert property (p_switch)
    else $error("switch at wrong count");
  property p_wrap;
    @(posedge clk) disable iff (!rst_n)
    s_q.st == FCS_RUN && s_q.cnt == 8'hFF && frame_tick && !init_req && !ho_req
    |=> connection_frame_count == 8'h00;
  endproperty
  a_wrap: assert property (p_wrap)
    else $error("count did not wrap to zero");
endmodule

// File: sim/fcs_ctl_model.sv
// Controller side: turns a handover command into ho_req with the offset flag
module fcs_ctl_model
(
  input wire logic clk,
  input wire logic go,
  input wire logic known,
  output logic ho_req,
  output logic ho_new_doff
);
  timeunit 1ns;
  timeprecision 1ps;
  // New default offset only when the target offset is unknown
  always @(posedge clk)
  begin
    ho_req <= go;
    ho_new_doff <= go & ~known;
  end
endmodule

// File: sim/fcs_frame_counter_tb.sv
module fcs_frame_counter_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import fcs_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  fcs_mode_t mode = FCS_MODE_FDD;
  logic frame_tick = 1'b0, init_req = 1'b0, ho_frame_valid = 1'b0, rep_req = 1'b0;
  logic go = 1'b0, known = 1'b0, rep_measurable = 1'b0, rep_to_tdd = 1'b0, cfg_arm = 1'b0;
  logic [11:0] cell_frame_number = 12'h000, rep_frame_number = 12'h000;
  logic [9:0] default_offset_fdd = 10'h000;
  logic [7:0] default_offset_tdd = 8'h00, cfg_switch_count = 8'h00;
  logic [15:0] rep_chip = 16'h0000;
  logic ho_req, ho_new_doff, count_valid, cfg_switch, cfg_pending, chip_offset_valid;
  logic report_valid;
  logic [7:0] connection_frame_count, frame_offset_report;
  logic [15:0] chip_offset_report;
  int error_cnt = 0;
  int n_tests = 0;
  // Clock, 5 ns period
  initial forever #2.5 clk = ~clk;
  fcs_ctl_model ctl (.clk, .go, .known, .ho_req, .ho_new_doff);
  fcs_frame_counter uut (.clk, .rst_n, .mode, .frame_tick, .init_req, .cell_frame_number,
    .default_offset_fdd, .default_offset_tdd, .ho_req, .ho_new_doff, .ho_frame_valid, .rep_req,
    .rep_frame_number, .rep_measurable, .rep_chip, .rep_to_tdd, .cfg_arm, .cfg_switch_count,
    .connection_frame_count, .count_valid, .cfg_switch, .cfg_pending, .frame_offset_report,
    .chip_offset_report, .chip_offset_valid, .report_valid);
  task automatic chk(string what, logic [15:0] exp, logic [15:0] got);
    n_tests++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic conclude();
    $display("Checks %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // One frame tick; returns with the count settled
  task automatic tick();
    @(posedge clk);
    frame_tick <= 1'b1;
    @(posedge clk);
    frame_tick <= 1'b0;
    #1;
  endtask
  task automatic init(logic [11:0] fn, logic [9:0] df, logic [7:0] dt, fcs_mode_t md);
    @(posedge clk);
    mode <= md;
    cell_frame_number <= fn;
    default_offset_fdd <= df;
    default_offset_tdd <= dt;
    init_req <= 1'b1;
    @(posedge clk);
    init_req <= 1'b0;
    #1;
  endtask
  // One report request, bounded wait for report_valid
  task automatic rep(logic [11:0] fn, logic ms, logic td, logic [7:0] eo, logic [15:0] ec);
    int i;
    @(posedge clk);
    rep_frame_number <= fn;
    rep_measurable <= ms;
    rep_to_tdd <= td;
    rep_chip <= 16'h1234;
    rep_req <= 1'b1;
    @(posedge clk);
    rep_req <= 1'b0;
    #1;
    for (i = 0; i < 4 && report_valid !== 1'b1; i++)
      @(posedge clk) #1;
    chk("report_valid", 16'h0001, {15'h0000, report_valid});
    if (i == 4)
      conclude();
    chk("frame_offset_report", {8'h00, eo}, {8'h00, frame_offset_report});
    chk("chip_offset_report", ec, chip_offset_report);
    chk("chip_offset_valid", {15'h0000, mode == FCS_MODE_FDD && !td},
      {15'h0000, chip_offset_valid});
  endtask
  task automatic ho(logic kn, logic [9:0] df);
    @(posedge clk);
    known <= kn;
    default_offset_fdd <= df;
    go <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
    repeat (3) @(posedge clk);
    #1;
  endtask
  task automatic t_reset();
    chk("count", 16'h0000, {8'h00, connection_frame_count});
    chk("count_valid", 16'h0000, {15'h0000, count_valid});
    chk("off", 16'h00FF, {8'h00, frame_offset_report});
    chk("chip", 16'hFFFF, chip_offset_report);
    chk("cfg_switch", 16'h0000, {15'h0000, cfg_switch});
    chk("cfg_pending", 16'h0000, {15'h0000, cfg_pending});
    chk("report_valid", 16'h0000, {15'h0000, report_valid});
    chk("chip_offset_valid", 16'h0000, {15'h0000, chip_offset_valid});
    $display("Test reset done");
  endtask
  task automatic t_count();
    init(12'h105, 10'h064, 8'h00, FCS_MODE_FDD);
    chk("count", 16'h0004, {8'h00, connection_frame_count});
    chk("count_valid", 16'h0001, {15'h0000, count_valid});
    tick();
    chk("count", 16'h0005, {8'h00, connection_frame_count});
    init(12'h0FF, 10'h000, 8'h00, FCS_MODE_FDD);
    tick();
    chk("count", 16'h0000, {8'h00, connection_frame_count});
    init(12'h003, 10'h000, 8'h05, FCS_MODE_TDD);
    chk("count", 16'h00FE, {8'h00, connection_frame_count});
    $display("Test count done");
  endtask
  task automatic t_report();
    rep(12'h010, 1'b1, 1'b0, 8'h12, 16'h1234);
    rep(12'h010, 1'b0, 1'b0, 8'hFF, 16'hFFFF);
    init(12'h020, 10'h000, 8'h00, FCS_MODE_FDD);
    rep(12'h105, 1'b1, 1'b0, 8'hE5, 16'h1234);
    rep(12'h105, 1'b1, 1'b1, 8'hE5, 16'h1234);
    rep(12'h105, 1'b0, 1'b0, 8'hFF, 16'hFFFF);
    $display("Test report done");
  endtask
  // Target frame number becomes readable after a handover
  task automatic fn_arrive(logic [11:0] fn);
    @(posedge clk);
    cell_frame_number <= fn;
    ho_frame_valid <= 1'b1;
    @(posedge clk);
    ho_frame_valid <= 1'b0;
    #1;
  endtask
  task automatic t_handover();
    ho(1'b1, 10'h0C8);
    chk("count", 16'h0020, {8'h00, connection_frame_count});
    fn_arrive(12'h0AB);
    chk("count", 16'h0020, {8'h00, connection_frame_count});
    ho(1'b0, 10'h0C8);
    fn_arrive(12'h030);
    chk("count", 16'h002E, {8'h00, connection_frame_count});
    @(posedge clk);
    mode <= FCS_MODE_TDD;
    default_offset_tdd <= 8'h07;
    ho(1'b0, 10'h000);
    fn_arrive(12'h040);
    chk("count", 16'h0039, {8'h00, connection_frame_count});
    $display("Test handover done");
  endtask
  task automatic t_switch();
    @(posedge clk);
    cfg_switch_count <= 8'h3B;
    cfg_arm <= 1'b1;
    @(posedge clk);
    cfg_arm <= 1'b0;
    #1;
    chk("cfg_pending", 16'h0001, {15'h0000, cfg_pending});
    tick();
    chk("cfg_switch", 16'h0000, {15'h0000, cfg_switch});
    tick();
    chk("cfg_switch", 16'h0001, {15'h0000, cfg_switch});
    chk("count", 16'h003B, {8'h00, connection_frame_count});
    @(posedge clk) #1;
    chk("cfg_switch", 16'h0000, {15'h0000, cfg_switch});
    chk("cfg_pending", 16'h0000, {15'h0000, cfg_pending});
    $display("Test switch done");
  endtask
  // Reset for 5 cycles, then the scenarios
  initial
  begin
    repeat (4) @(posedge clk);
    #1;
    t_reset();
    @(posedge clk);
    rst_n <= 1'b1;
    t_count();
    t_report();
    t_handover();
    t_switch();
    conclude();
  end
endmodule
